/* File: rtl/atu_consts.vh */
`ifndef ATU_CONSTS_VH
`define ATU_CONSTS_VH
// address layout
`define ATU_VA_W        32
`define ATU_PA_W        32
`define ATU_PAGE_SHIFT  12
`define ATU_VPN_W       20
`define ATU_PFN_W       20
// sources and cache
`define ATU_NSRC        7
`define ATU_NENT        8
`define ATU_IDX_W       3
`define ATU_CNT_W       3
`define ATU_CNT_RST     3'h0
// phases
`define ATU_PH_NORMAL   1'b0
`define ATU_PH_MISS     1'b1
`endif

/* File: rtl/atu_arbiter.v */
`include "atu_consts.vh"
// round-robin pick of one source among the pending ones
module atu_arbiter
(
    input  wire                    mclk_i,
    input  wire                    rst_i,
    input  wire                    ce_i,
    input  wire [`ATU_NSRC-1:0]    req_i,
    input  wire                    take_i,
    output reg  [`ATU_IDX_W-1:0]   sel_o,
    output reg                     any_o
);
    reg [`ATU_IDX_W-1:0] last;
    reg [`ATU_IDX_W-1:0] cand;
    integer              k;
    // search starting just after the last winner
    always @*
    begin
        sel_o = {`ATU_IDX_W{1'b0}};
        any_o = 1'b0;
        cand  = last;
        for (k = 0; k < `ATU_NSRC; k = k + 1)
        begin
            cand = (cand == `ATU_NSRC - 1) ? {`ATU_IDX_W{1'b0}} : cand + 3'h1;
            if (!any_o && req_i[cand])
            begin
                sel_o = cand;
                any_o = 1'b1;
            end
        end
    end
    // remember winner
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            last <= 3'h6;               // last source, so the first search starts at source 0
        else if (ce_i && take_i)
            last <= sel_o;
    end
endmodule

/* File: rtl/atu_translator.v */
`include "atu_consts.vh"
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - translate virtual to physical addresses on fixed 4 KB pages
// - fetch page entries from external memory only on demand
// - cache recent page entries; compare each request address for hit
// - hit: physical page bits joined with virtual page offset bits
// - miss: fetch entry, hold the request until fetch completes
// - accept 7 parallel sources; all missing together loses none
// - 3 bit outstanding miss counter, up on miss, down on service
// - miss phase while misses remain; back to normal at zero
module atu_translator
(
    input  wire                            mclk_i,
    input  wire                            rst_i,
    input  wire                            ce_i,
    input  wire [`ATU_NSRC-1:0]            req_valid_i,
    input  wire [`ATU_NSRC*`ATU_VA_W-1:0]  req_vaddr_i,
    output wire [`ATU_NSRC-1:0]            req_ready_o,
    output reg                             out_valid_o,
    output reg  [`ATU_PA_W-1:0]            out_paddr_o,
    output reg  [`ATU_IDX_W-1:0]           out_src_o,
    input  wire                            out_ready_i,
    output reg                             fetch_valid_o,
    output reg  [`ATU_VPN_W-1:0]           fetch_vpn_o,
    input  wire                            fetch_ready_i,
    input  wire                            fetch_done_i,
    input  wire [`ATU_PFN_W-1:0]           fetch_pfn_i,
    input  wire                            invalidate_i,
    output wire                            miss_phase_o,
    output wire [`ATU_CNT_W-1:0]           miss_count_o
);
    ////////////////////////////////////////////////////////////////////////////
    // state
    reg  [`ATU_VPN_W-1:0]  tag   [0:`ATU_NENT-1];
    reg  [`ATU_PFN_W-1:0]  pfn   [0:`ATU_NENT-1];
    reg  [`ATU_NENT-1:0]   valid;
    reg  [`ATU_IDX_W-1:0]  repl;
    reg  [`ATU_NSRC-1:0]   waiting;    // sources parked on a miss
    reg  [`ATU_NSRC-1:0]   queued;     // parked sources whose fetch is not yet sent
    reg  [`ATU_CNT_W-1:0]  cnt;
    reg                    phase;
    reg                    busy_fetch;
    reg  [`ATU_VPN_W-1:0]  fetch_tag;

    wire [`ATU_IDX_W-1:0]  sel;
    wire                   any;
    wire [`ATU_VA_W-1:0]   va;
    wire [`ATU_VPN_W-1:0]  vpn;
    reg                    hit;
    reg  [`ATU_PFN_W-1:0]  hit_pfn;
    integer                e;
    wire                   take;
    wire                   issue;
    reg  [`ATU_NSRC-1:0]   fetch_mask;

    assign miss_phase_o = phase;
    assign miss_count_o = cnt;

    ////////////////////////////////////////////////////////////////////////////
    // one source at a time is presented to the lookup
    atu_arbiter u_arb
    (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .req_i  (req_valid_i & ~waiting),
        .take_i (take),
        .sel_o  (sel),
        .any_o  (any)
    );

    assign va  = req_vaddr_i[sel*`ATU_VA_W +: `ATU_VA_W];
    assign vpn = va[`ATU_VA_W-1:`ATU_PAGE_SHIFT];

    // tag compare against every cached entry
    always @*
    begin
        hit     = 1'b0;
        hit_pfn = {`ATU_PFN_W{1'b0}};
        for (e = 0; e < `ATU_NENT; e = e + 1)
        begin
            if (valid[e] && tag[e] == vpn)
            begin
                hit     = 1'b1;
                hit_pfn = pfn[e];
            end
        end
    end

    // output stage free, and a miss never bumps the counter past seven sources
    wire out_free = !out_valid_o || out_ready_i;
    // a grant only shows on an enabled edge, so a frozen cycle never drops a request
    assign take   = ce_i && any && (hit ? out_free : 1'b1) && !invalidate_i;
    wire do_hit   = take && hit;
    wire do_miss  = take && !hit;
    wire [`ATU_NSRC-1:0] sel_mask = {{(`ATU_NSRC-1){1'b0}}, 1'b1} << sel;

    // grant: the picked source gets ready only on a hit; on a miss it is parked with no grant
    assign req_ready_o = do_hit ? sel_mask : {`ATU_NSRC{1'b0}};

    ////////////////////////////////////////////////////////////////////////////
    // pick the next queued miss to fetch (lowest index)
    reg  [`ATU_IDX_W-1:0] qsel;
    reg                   qany;
    integer               q;
    always @*
    begin
        qsel = {`ATU_IDX_W{1'b0}};
        qany = 1'b0;
        for (q = `ATU_NSRC - 1; q >= 0; q = q - 1)
        begin
            if (queued[q])
            begin
                qsel = q[`ATU_IDX_W-1:0];
                qany = 1'b1;
            end
        end
    end
    wire [`ATU_VA_W-1:0] qva = req_vaddr_i[qsel*`ATU_VA_W +: `ATU_VA_W];

    // a finished fetch releases every parked source of the same page
    reg [`ATU_NSRC-1:0] release_mask;
    integer             r;
    always @*
    begin
        release_mask = {`ATU_NSRC{1'b0}};
        for (r = 0; r < `ATU_NSRC; r = r + 1)
        begin
            if (fetch_done_i && busy_fetch && waiting[r] &&
                req_vaddr_i[r*`ATU_VA_W+`ATU_PAGE_SHIFT +: `ATU_VPN_W] == fetch_tag)
                release_mask[r] = 1'b1;
        end
    end
    wire fetch_svc = fetch_done_i && busy_fetch;

    ////////////////////////////////////////////////////////////////////////////
    // per-source parking: one outstanding miss per source at most
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            waiting <= {`ATU_NSRC{1'b0}};
            queued  <= {`ATU_NSRC{1'b0}};
        end
        else if (ce_i)
        begin
            // a source leaves the queue when its own fetch goes out or its page arrives
            waiting <= (waiting & ~release_mask) | (do_miss ? sel_mask : 7'h0);
            queued  <= (queued & ~release_mask & ~(issue ? fetch_mask : 7'h0))
                       | (do_miss ? sel_mask : 7'h0);
        end
    end
    // one-hot of the queued source whose fetch is issued now
    always @*
    begin
        fetch_mask = {{(`ATU_NSRC-1){1'b0}}, 1'b1} << qsel;
    end

    ////////////////////////////////////////////////////////////////////////////
    // external fetch: one at a time, only for a parked miss
    // queue bit is dropped at issue, so a later park cannot steal the pending fetch
    assign issue = !busy_fetch && qany && !fetch_valid_o;
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fetch_valid_o <= 1'b0;
            fetch_vpn_o   <= {`ATU_VPN_W{1'b0}};
            fetch_tag     <= {`ATU_VPN_W{1'b0}};
            busy_fetch    <= 1'b0;
        end
        else if (ce_i)
        begin
            if (fetch_valid_o && fetch_ready_i)
                fetch_valid_o <= 1'b0;
            else if (issue)
            begin
                fetch_valid_o <= 1'b1;
                fetch_vpn_o   <= qva[`ATU_VA_W-1:`ATU_PAGE_SHIFT];
                fetch_tag     <= qva[`ATU_VA_W-1:`ATU_PAGE_SHIFT];
                busy_fetch    <= 1'b1;
            end
            if (fetch_svc)
                busy_fetch <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cache fill on fetch completion, round-robin replacement
    genvar g;
    generate
        for (g = 0; g < `ATU_NENT; g = g + 1)
        begin : g_ent
            always @(posedge mclk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    tag[g]   <= {`ATU_VPN_W{1'b0}};
                    pfn[g]   <= {`ATU_PFN_W{1'b0}};
                    valid[g] <= 1'b0;
                end
                else if (ce_i)
                begin
                    if (fetch_svc && repl == g)
                    begin
                        tag[g]   <= fetch_tag;
                        pfn[g]   <= fetch_pfn_i;
                        valid[g] <= 1'b1;
                    end
                    else if (invalidate_i)
                        valid[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            repl <= {`ATU_IDX_W{1'b0}};
        else if (ce_i && fetch_svc)
            repl <= repl + 3'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outstanding miss counter and phase
    wire [`ATU_CNT_W-1:0] n_rel = {2'b00, release_mask[0]} + {2'b00, release_mask[1]}
                                + {2'b00, release_mask[2]} + {2'b00, release_mask[3]}
                                + {2'b00, release_mask[4]} + {2'b00, release_mask[5]}
                                + {2'b00, release_mask[6]};
    wire [`ATU_CNT_W-1:0] next_cnt = cnt + (do_miss ? 3'h1 : 3'h0) - n_rel;
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt   <= `ATU_CNT_RST;
            phase <= `ATU_PH_NORMAL;
        end
        else if (ce_i)
        begin
            cnt   <= next_cnt;
            phase <= (next_cnt != 3'h0) ? `ATU_PH_MISS : `ATU_PH_NORMAL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // translated request output register
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            out_valid_o <= 1'b0;
            out_paddr_o <= {`ATU_PA_W{1'b0}};
            out_src_o   <= {`ATU_IDX_W{1'b0}};
        end
        else if (ce_i)
        begin
            if (do_hit)
            begin
                out_valid_o <= 1'b1;
                out_paddr_o <= {hit_pfn, va[`ATU_PAGE_SHIFT-1:0]};
                out_src_o   <= sel;
            end
            else if (out_ready_i)
                out_valid_o <= 1'b0;
        end
    end
endmodule

/* File: tb/atu_translator_asserts.sv */
module atu_chk
(
    input logic         mclk_i,
    input logic         rst_i,
    input logic         ce_i,
    input logic [6:0]   req_valid_i,
    input logic [223:0] req_vaddr_i,
    input logic [6:0]   req_ready_o,
    input logic         out_valid_o,
    input logic [31:0]  out_paddr_o,
    input logic [2:0]   out_src_o,
    input logic         out_ready_i,
    input logic         fetch_valid_o,
    input logic [19:0]  fetch_vpn_o,
    input logic         fetch_ready_i,
    input logic         invalidate_i,
    input logic         miss_phase_o,
    input logic [2:0]   miss_count_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0]  gidx;
    logic [11:0] goff;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // index and page offset of the granted source
    always_comb
    begin
        gidx = 3'h0;
        for (int i = 0; i < 7; i++)
            if (req_ready_o[i])
                gidx = i[2:0];
        goff = req_vaddr_i[gidx*32 +: 12];
    end
    sequence grant_s;
        ce_i && |req_ready_o;
    endsequence
    sequence stall_s;
        ce_i && out_valid_o && !out_ready_i;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    one_grant_a: assert property ($onehot0(req_ready_o))
        else $error("two grants");
    grant_req_a: assert property ((req_ready_o & ~req_valid_i) == 7'h00)
        else $error("grant without request");
    grant_src_a: assert property (grant_s |=> out_valid_o && out_src_o == $past(gidx))
        else $error("wrong source");
    page_off_a: assert property (grant_s |=> out_paddr_o[11:0] == $past(goff))
        else $error("wrong page offset");
    out_hold_a: assert property (stall_s |=> out_valid_o && $stable(out_paddr_o))
        else $error("output dropped");
    fetch_hold_a: assert property (ce_i && fetch_valid_o && !fetch_ready_i |=>
        fetch_valid_o && $stable(fetch_vpn_o)) else $error("fetch dropped");
    phase_cnt_a: assert property (miss_phase_o == (miss_count_o != 3'h0))
        else $error("phase and count disagree");
    miss_fetch_a: assert property ($rose(miss_phase_o) && ce_i |=> fetch_valid_o)
        else $error("miss without fetch");
    inval_stop_a: assert property (invalidate_i |-> req_ready_o == 7'h00)
        else $error("grant during invalidate");
    fetch_cnt_a: assert property ($rose(fetch_valid_o) |-> miss_count_o != 3'h0)
        else $error("fetch not counted");
endmodule
bind atu_translator atu_chk u_chk (.*);

/* File: tb/atu_mem_model.sv */
module atu_mem_model
#(
    parameter logic [19:0] PFN_XOR = 20'hA_5C3E
)
(
    input  logic        mclk_i,
    input  logic        rst_i,
    input  logic [3:0]  dly_i,
    input  logic        fetch_valid_i,
    input  logic [19:0] fetch_vpn_i,
    output logic        fetch_ready_o,
    output logic        fetch_done_o,
    output logic [19:0] fetch_pfn_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        busy;
    logic [3:0]  cnt;
    logic [19:0] vpn;
    // take a fetch after the chosen wait, one in flight
    assign fetch_ready_o = fetch_valid_i && !busy && cnt >= dly_i;
    // return the entry after the wait; an idle return bus keeps toggling
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            busy         <= 1'b0;
            cnt          <= 4'h0;
            vpn          <= 20'h0_0000;
            fetch_done_o <= 1'b0;
            fetch_pfn_o  <= 20'h0_0000;
        end
        else
        begin
            fetch_done_o <= 1'b0;
            fetch_pfn_o  <= ~fetch_pfn_o;
            cnt          <= cnt + 4'h1;
            if (busy && cnt >= dly_i)
            begin
                busy         <= 1'b0;
                cnt          <= 4'h0;
                fetch_done_o <= 1'b1;
                fetch_pfn_o  <= vpn ^ PFN_XOR;
            end
            else if (fetch_ready_o)
            begin
                busy <= 1'b1;
                cnt  <= 4'h0;
                vpn  <= fetch_vpn_i;
            end
            else if (!fetch_valid_i && !busy)
                cnt <= 4'h0;
        end
    end
endmodule

/* File: tb/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [19:0] PFN_XOR = 20'hA_5C3E;
    logic         mclk_i = 0, rst_i = 1, ce_i = 1, out_ready_i = 1, invalidate_i = 0;
    logic [6:0]   req_valid_i = 7'h00, req_ready_o;
    logic [223:0] req_vaddr_i = '0;
    logic         out_valid_o, fetch_valid_o, fetch_ready_i, fetch_done_i, miss_phase_o;
    logic [31:0]  out_paddr_o, got [7];
    logic [2:0]   out_src_o, miss_count_o, max_cnt;
    logic [19:0]  fetch_vpn_o, fetch_pfn_i;
    logic [3:0]   dly = 4'h0;
    int           errors = 0, checks = 0, nfetch = 0, cyc = 0;
    atu_translator u_dut (.*);
    atu_mem_model u_mem (.mclk_i(mclk_i), .rst_i(rst_i), .dly_i(dly),
        .fetch_valid_i(fetch_valid_o), .fetch_vpn_i(fetch_vpn_o), .fetch_ready_o(fetch_ready_i),
        .fetch_done_o(fetch_done_i), .fetch_pfn_o(fetch_pfn_i));
    initial forever #20 mclk_i = ~mclk_i;
    // drop granted requests, record outputs, count fetches, cut a hang short
    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        req_valid_i <= req_valid_i & ~req_ready_o;
        if (out_valid_o && out_ready_i)
            got[out_src_o] <= out_paddr_o;
        if (fetch_valid_o && fetch_ready_i)
            nfetch <= nfetch + 1;
        if (miss_count_o > max_cnt)
            max_cnt <= miss_count_o;
        if (cyc == 32'h0000_4E20)
        begin
            errors = errors + 1;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp_addr(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected at %0t: address %h, want %h", $time, g, e);
        end
    endtask
    task automatic cmp_num(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected at %0t: count %0d, want %0d", $time, g, e);
        end
    endtask
    // source i asks for va + i * st; output stalled for the first hold cycles
    task automatic run(input logic [6:0] m, input logic [31:0] va, input logic [31:0] st,
                       input int hold, input int nf, input int mx);
        logic [31:0] a;
        int n;
        int f;
        @(negedge mclk_i);
        f = nfetch;
        max_cnt = 3'h0;
        for (int i = 0; i < 7; i++)
        begin
            got[i] = 32'h0000_0000;
            req_vaddr_i[i*32 +: 32] = va + i * st;
        end
        req_valid_i = m;
        n = 0;
        do
        begin
            @(negedge mclk_i);
            out_ready_i = (n >= hold);
            n++;
        end
        while ((req_valid_i != 7'h00 || out_valid_o || miss_phase_o) && n < 400);
        if (n >= 400)
        begin
            errors++;
            $display("unexpected at %0t: scenario did not settle", $time);
        end
        for (int i = 0; i < 7; i++)
            if (m[i])
            begin
                a = va + i * st;
                cmp_addr(got[i], {a[31:12] ^ PFN_XOR, a[11:0]});
            end
        cmp_num(nfetch - f, nf);
        cmp_num(max_cnt, mx);
        cmp_num(miss_count_o, 0);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(negedge mclk_i);
        rst_i = 1'b0;
        cmp_num(miss_count_o, 0);
        cmp_num(miss_phase_o, 0);
        run(7'h04, 32'h1234_5678, 32'h0000_0000, 0, 1, 1);
        $display("test single miss done");
        dly = 4'h4;
        run(7'h03, 32'h1234_5ABC, 32'h0000_0100, 0, 0, 0);
        $display("test back to back hit done");
        dly = 4'h9;
        run(7'h7F, 32'h0040_0010, 32'h0000_1004, 30, 7, 7);
        $display("test all sources miss done");
        // pulse invalidate only while idle
        invalidate_i = 1'b1;
        @(negedge mclk_i);
        invalidate_i = 1'b0;
        run(7'h04, 32'h1234_5678, 32'h0000_0000, 0, 1, 1);
        $display("test invalidate done");
        // three sources miss on one page: one fetch releases all of them at once
        run(7'h70, 32'h0080_0000, 32'h0000_0004, 0, 1, 3);
        $display("test shared page miss done");
        finish_test();
    end
endmodule
